//--- hw/slcs_pkg.sv
// Constants, register map and types shared by both ends of the link configuration path.
// Function
// [R1] Single-channel select disables channels B, C, D.
// [R2] Software keeps first pair enabled in single mode.
// [R3] Second pair enable bit gates channels C, D.
// [R4] First pair enable bit zero gates A, B.
// [R5] Channel enables change only with link, calibration off.
// [R6] Never clear every channel enable for power-down.
// [R7] One pair off halves lanes (ceiling), converters.
// [R8] Odd lane count, pair off: pad highest lane.
// [R9] First pair off: C, D take A, B slots.
// [R10] Software writes zero to reserved enable bits.
// [R11] Header field: 0 CRC-12, 2 FEC, else reserved.
// [R12] 32-bit sync word; selection applies only 64B/66B.
// [R13] Command fields always zero, idle headers sent.
// [R14] Header and threshold change only with link off.
// [R15] Sync request input sampled every link-clock cycle.
// [R16] Request after threshold plus one consecutive lows.
// [R17] Shorter low runs are error reports, ignored.
// [R18] Receiver should disable error reports, threshold zero.
// [R19] Status bit shows sync level, 0 asserted.
// [R20] Any high sample clears the consecutive-low count.
package slcs_pkg;
    localparam int DEV_AW = 10;
    localparam int DEV_DW = 8;
    localparam logic [9:0] OFS_LINK_CTRL = 10'h200;
    localparam logic [9:0] OFS_LINK_STATUS = 10'h208;
    localparam logic [9:0] OFS_CHANNEL_PAIR_ENABLES = 10'h209;
    localparam logic [9:0] OFS_HEADER_WORD_SELECT = 10'h20F;
    localparam logic [9:0] OFS_SYNC_REQUEST_COUNT_LIMIT = 10'h210;
    localparam int BIT_FIRST_PAIR = 0;
    localparam int BIT_SECOND_PAIR = 1;
    localparam int BIT_ONE_CHANNEL = 2;
    localparam int BIT_LINK_EN = 0;
    localparam int BIT_CAL_EN = 1;
    localparam int BIT_MODE_66B = 2;
    localparam int BIT_SYNC_LEVEL = 5;
    localparam logic [2:0] RST_CHANNEL_PAIR_ENABLES = 3'h3;
    localparam logic [1:0] RST_HEADER_WORD_SELECT = 2'h0;
    localparam logic [4:0] RST_SYNC_REQUEST_COUNT_LIMIT = 5'h03;
    localparam logic [2:0] RST_LINK_CTRL = 3'h0;
    localparam logic [2:0] MASK_CHANNEL_PAIR_ENABLES = 3'h7;
    localparam logic [1:0] MASK_HEADER_WORD_SELECT = 2'h3;
    localparam logic [4:0] MASK_SYNC_REQUEST_COUNT_LIMIT = 5'h1F;
    localparam int SYNC_WORD_BITS = 32;
    localparam int LINK_DIV = 2;
    localparam int RUN_W = 6;
    typedef enum logic [1:0] {
        SLCS_HDR_CRC12 = 2'b00,
        SLCS_HDR_RSVD1 = 2'b01,
        SLCS_HDR_FEC = 2'b10,
        SLCS_HDR_RSVD3 = 2'b11
    } slcs_hdr_t;
    localparam logic [7:0] AHB_OFS_CMD = 8'h00;
    localparam logic [7:0] AHB_OFS_STAT = 8'h04;
    localparam logic [7:0] AHB_OFS_SYNC = 8'h08;
    localparam int CMD_DATA_LSB = 10;
    localparam int CMD_WRITE_BIT = 31;
    localparam int STAT_BUSY = 0;
    localparam int STAT_REFUSED = 1;
    localparam int STAT_RDATA_LSB = 8;
endpackage

//--- hw/slcs_link_if.sv
// Interface joining the controller end and the converter end: register port and sync request.
`timescale 1ns/100ps
`default_nettype none
interface slcs_link_if;
    logic reg_req;
    logic reg_wr;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_ack;
    logic [7:0] reg_rdata;
    logic sync_n;
    modport dev (
        input reg_req, reg_wr, reg_addr, reg_wdata, sync_n,
        output reg_ack, reg_rdata
    );
    modport host (
        output reg_req, reg_wr, reg_addr, reg_wdata, sync_n,
        input reg_ack, reg_rdata
    );
endinterface
`default_nettype wire

//--- hw/slcs_device.sv
// Converter end: channel configuration registers, header selection and sync request qualifier.
`timescale 1ns/100ps
`default_nettype none
module slcs_device (
    input wire logic clk, // System clock, 25 MHz.
    input wire logic rst, // Synchronous reset, active high.
    slcs_link_if.dev link, // Register port and sync request from the receiver.
    input wire logic [3:0] nominal_lane_count, // Lane count with all channels on.
    input wire logic [3:0] nominal_converter_count, // Converter count with all channels on.
    output logic [3:0] channel_active_q, // Per-channel enable, bit 0 is channel A.
    output logic [3:0] lane_count_q, // Lanes in use.
    output logic [3:0] converter_count_q, // Converters in use.
    output logic tail_pad_q, // Pad the end of the highest lane.
    output logic second_pair_in_first_slots_q, // C and D samples sit in A and B slots.
    output logic header_crc_q, // Sync word carries CRC-12.
    output logic header_fec_q, // Sync word carries FEC.
    output logic [slcs_pkg::SYNC_WORD_BITS-1:0] command_field_q, // Command bits, always zero.
    output logic link_tick_q, // Link-clock enable, one pulse per link cycle.
    output logic sync_request_q, // Qualified synchronisation request, level.
    output logic sync_error_q, // Short low run seen, one-cycle pulse.
    output logic sync_level_q // Filtered sync level, low means asserted.
);
    import slcs_pkg::*;

    localparam int DIV_W = $clog2(LINK_DIV);

    logic [2:0] chen_q;
    logic [1:0] hdr_sel_q;
    logic [4:0] thresh_q;
    logic [2:0] link_ctrl_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic [RUN_W-1:0] run_q;
    logic [$clog2(LINK_DIV)-1:0] div_q;
    logic pair_off;
    logic single_mode;
    logic first_on;
    logic second_on;
    logic mode_66b;

    assign link.reg_ack = ack_q;
    assign link.reg_rdata = rdata_q;

    assign single_mode = chen_q[BIT_ONE_CHANNEL];
    assign first_on = chen_q[BIT_FIRST_PAIR];
    assign second_on = chen_q[BIT_SECOND_PAIR] && !single_mode;
    assign pair_off = !first_on || !second_on;
    assign mode_66b = link_ctrl_q[BIT_MODE_66B];

    // Register writes; only defined fields are stored, so reserved bits read back as zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            chen_q <= RST_CHANNEL_PAIR_ENABLES;
            hdr_sel_q <= RST_HEADER_WORD_SELECT;
            thresh_q <= RST_SYNC_REQUEST_COUNT_LIMIT;
            link_ctrl_q <= RST_LINK_CTRL;
        end else if (link.reg_req && link.reg_wr) begin
            unique case (link.reg_addr)
                OFS_CHANNEL_PAIR_ENABLES: begin
                    chen_q <= link.reg_wdata[2:0];
                end
                OFS_HEADER_WORD_SELECT: begin
                    hdr_sel_q <= link.reg_wdata[1:0];
                end
                OFS_SYNC_REQUEST_COUNT_LIMIT: begin
                    thresh_q <= link.reg_wdata[4:0];
                end
                OFS_LINK_CTRL: begin
                    link_ctrl_q <= link.reg_wdata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        unique case (link.reg_addr)
            OFS_CHANNEL_PAIR_ENABLES: rdata_d = {5'h00, chen_q};
            OFS_HEADER_WORD_SELECT: rdata_d = {6'h00, hdr_sel_q};
            OFS_SYNC_REQUEST_COUNT_LIMIT: rdata_d = {3'h0, thresh_q};
            OFS_LINK_CTRL: rdata_d = {5'h00, link_ctrl_q};
            OFS_LINK_STATUS: rdata_d[BIT_SYNC_LEVEL] = sync_level_q; // R19
            default: rdata_d = 8'h00;
        endcase
    end

    // Every request is answered on the following edge; unmapped addresses read zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q <= link.reg_req;
            if (link.reg_req && !link.reg_wr) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Channel enables and the resulting lane and converter scaling.
    always_ff @(posedge clk) begin
        if (rst) begin
            channel_active_q <= 4'hF;
            lane_count_q <= 4'h0;
            converter_count_q <= 4'h0;
            tail_pad_q <= 1'b0;
            second_pair_in_first_slots_q <= 1'b0;
        end else begin
            if (single_mode) begin
                channel_active_q <= 4'h1; // R1
            end else begin
                channel_active_q <= {second_on, second_on, first_on, first_on}; // R3 R4
            end
            if (pair_off) begin
                lane_count_q <= 4'((5'(nominal_lane_count) + 5'h01) >> 1); // R7
                converter_count_q <= nominal_converter_count >> 1; // R7
            end else begin
                lane_count_q <= nominal_lane_count;
                converter_count_q <= nominal_converter_count;
            end
            tail_pad_q <= pair_off && nominal_lane_count[0]; // R8
            second_pair_in_first_slots_q <= !first_on && second_on; // R9
        end
    end

    // Header selection acts only in 64B/66B modes; reserved codes select neither payload.
    always_ff @(posedge clk) begin
        if (rst) begin
            header_crc_q <= 1'b0;
            header_fec_q <= 1'b0;
            command_field_q <= '0;
        end else begin
            header_crc_q <= mode_66b && (hdr_sel_q == SLCS_HDR_CRC12); // R11 R12
            header_fec_q <= mode_66b && (hdr_sel_q == SLCS_HDR_FEC); // R11 R12
            command_field_q <= '0; // R13
        end
    end

    // Divider that makes the link-clock enable at half the system rate.
    // It starts at its wrap point so the first tick keeps the one-in-two cadence after reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= DIV_W'(LINK_DIV - 1);
            link_tick_q <= 1'b0;
        end else begin
            link_tick_q <= (div_q == DIV_W'(LINK_DIV - 1));
            if (div_q == DIV_W'(LINK_DIV - 1)) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // Three-stage input chain; the filtered level moves only when the last two stages agree.
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            sync_level_q <= 1'b1;
        end else begin
            s1_q <= link.sync_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync_level_q <= s3_q; // R19
            end
        end
    end

    // Consecutive-low run counter; saturates so a long request stays qualified.
    always_ff @(posedge clk) begin
        if (rst) begin
            run_q <= '0;
            sync_request_q <= 1'b0;
            sync_error_q <= 1'b0;
        end else begin
            sync_error_q <= 1'b0;
            if (link_tick_q) begin // R15
                if (!sync_level_q) begin
                    if (run_q != {RUN_W{1'b1}}) begin
                        run_q <= run_q + 1'b1;
                    end
                    if (run_q >= RUN_W'(thresh_q)) begin
                        sync_request_q <= 1'b1; // R16
                    end
                end else begin
                    run_q <= '0; // R20
                    sync_request_q <= 1'b0;
                    sync_error_q <= (run_q != '0) && !sync_request_q; // R17
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/slcs_host.sv
// Controller end: AHB-Lite slave that relays software accesses to the converter and drives sync.
`timescale 1ns/100ps
`default_nettype none
module slcs_host (
    input wire logic clk, // System clock, 25 MHz.
    input wire logic rst, // Synchronous reset, active high.
    slcs_link_if.host link, // Register port and sync request toward the converter.
    input wire logic hsel, // AHB slave select.
    input wire logic [31:0] haddr, // AHB address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write.
    input wire logic [2:0] hsize, // AHB size, word only.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic hreadyout, // AHB slave ready.
    output logic hresp, // AHB response, always OKAY.
    output logic [31:0] hrdata // AHB read data.
);
    import slcs_pkg::*;

    typedef enum logic {
        SLCS_IDLE = 1'b0,
        SLCS_WAIT = 1'b1
    } slcs_state_t;

    slcs_state_t state_q;
    logic dphase_q;
    logic dwrite_q;
    logic [7:0] daddr_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic req_q;
    logic wr_q;
    logic [9:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rd_q;
    logic refused_q;
    logic sync_n_q;
    logic [2:0] link_ctrl_q;
    logic cmd_wr;
    logic dev_wr;
    logic [9:0] dev_addr;
    logic [7:0] dev_data;
    logic [7:0] fixed_data;
    logic protected_reg;
    logic refuse;
    logic clear_refused;

    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign link.reg_req = req_q;
    assign link.reg_wr = wr_q;
    assign link.reg_addr = addr_q;
    assign link.reg_wdata = wdata_q;
    assign link.sync_n = sync_n_q;

    assign cmd_wr = dphase_q && dwrite_q && (daddr_q == AHB_OFS_CMD);
    assign clear_refused = dphase_q && dwrite_q && (daddr_q == AHB_OFS_STAT)
        && hwdata[STAT_REFUSED];
    assign dev_wr = hwdata[CMD_WRITE_BIT];
    assign dev_addr = hwdata[9:0];
    assign dev_data = hwdata[CMD_DATA_LSB +: 8];
    assign protected_reg = (dev_addr == OFS_CHANNEL_PAIR_ENABLES)
        || (dev_addr == OFS_HEADER_WORD_SELECT) || (dev_addr == OFS_SYNC_REQUEST_COUNT_LIMIT);

    always_comb begin
        fixed_data = dev_data;
        refuse = (state_q != SLCS_IDLE);
        if (dev_wr && protected_reg && (link_ctrl_q[BIT_LINK_EN] || link_ctrl_q[BIT_CAL_EN])) begin
            refuse = 1'b1; // R5 R14
        end
        if (dev_addr == OFS_CHANNEL_PAIR_ENABLES) begin
            fixed_data = {5'h00, dev_data[2:0] & MASK_CHANNEL_PAIR_ENABLES}; // R10
            if (dev_data[BIT_ONE_CHANNEL]) begin
                fixed_data[BIT_FIRST_PAIR] = 1'b1; // R2
            end
            if (dev_wr && !fixed_data[BIT_FIRST_PAIR] && !fixed_data[BIT_SECOND_PAIR]) begin
                refuse = 1'b1; // R6
            end
        end else if (dev_addr == OFS_HEADER_WORD_SELECT) begin
            fixed_data = {6'h00, dev_data[1:0] & MASK_HEADER_WORD_SELECT};
        end else if (dev_addr == OFS_SYNC_REQUEST_COUNT_LIMIT) begin
            fixed_data = {3'h0, dev_data[4:0] & MASK_SYNC_REQUEST_COUNT_LIMIT};
        end
    end

    // AHB address phase capture; read data is prepared for the data phase with no wait state.
    always_ff @(posedge clk) begin
        if (rst) begin
            dphase_q <= 1'b0;
            dwrite_q <= 1'b0;
            daddr_q <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h00000000;
        end else begin
            dphase_q <= hsel && hready && htrans[1];
            if (hsel && hready && htrans[1]) begin
                dwrite_q <= hwrite;
                daddr_q <= haddr[7:0];
                hrdata_q <= 32'h00000000;
                if (haddr[7:0] == AHB_OFS_STAT) begin
                    hrdata_q <= {16'h0000, rd_q, 6'h00, refused_q, state_q == SLCS_WAIT};
                end else if (haddr[7:0] == AHB_OFS_SYNC) begin
                    hrdata_q <= {31'h00000000, sync_n_q};
                end
            end
        end
    end

    // Access sequencer toward the converter; one request pulse, then wait for its answer.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= SLCS_IDLE;
            req_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 10'h000;
            wdata_q <= 8'h00;
            rd_q <= 8'h00;
            link_ctrl_q <= RST_LINK_CTRL;
        end else begin
            req_q <= 1'b0;
            unique case (state_q)
                SLCS_IDLE: begin
                    if (cmd_wr && !refuse) begin
                        req_q <= 1'b1;
                        wr_q <= dev_wr;
                        addr_q <= dev_addr;
                        wdata_q <= fixed_data;
                        state_q <= SLCS_WAIT;
                        if (dev_wr && dev_addr == OFS_LINK_CTRL) begin
                            link_ctrl_q <= fixed_data[2:0];
                        end
                    end
                end
                SLCS_WAIT: begin
                    if (link.reg_ack) begin
                        if (!wr_q) begin
                            rd_q <= link.reg_rdata;
                        end
                        state_q <= SLCS_IDLE;
                    end
                end
            endcase
        end
    end

    // Refused flag; a new refusal wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if (cmd_wr && refuse) begin
            refused_q <= 1'b1;
        end else if (clear_refused) begin
            refused_q <= 1'b0;
        end
    end

    // Sync request level under software control; it holds the last value written to the sync register, short runs included.
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_n_q <= 1'b1;
        end else if (dphase_q && dwrite_q && (daddr_q == AHB_OFS_SYNC)) begin
            sync_n_q <= hwdata[0]; // R18
        end
    end
endmodule
`default_nettype wire

//--- dv/slcs_link_assertions.sv
// Concurrent checks on the link signals and the converter end outputs.
`timescale 1ns/100ps
`default_nettype none
module slcs_link_assertions (
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic reg_req, // Register access request.
    input wire logic reg_ack, // Register access answer.
    input wire logic sync_n, // Sync request level from the controller.
    input wire logic [3:0] nominal_lane_count, // Lanes with all channels on.
    input wire logic [3:0] channel_active_q, // Per-channel enables.
    input wire logic [3:0] lane_count_q, // Lanes in use.
    input wire logic header_crc_q, // Sync word carries CRC-12.
    input wire logic header_fec_q, // Sync word carries FEC.
    input wire logic [31:0] command_field_q, // Command bits.
    input wire logic link_tick_q, // Link-clock enable.
    input wire logic sync_request_q, // Qualified request.
    input wire logic sync_error_q, // Short low run pulse.
    input wire logic sync_level_q // Filtered sync level.
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_ack_after_req: assert property (reg_req |=> reg_ack)
        else $error("reg_ack missing one cycle after reg_req");
    chk_ack_no_spur: assert property (!reg_req |=> !reg_ack)
        else $error("reg_ack without a request");
    chk_cmd_zero: assert property (command_field_q == 32'h0)
        else $error("command field not zero");
    chk_hdr_exclusive: assert property (!(header_crc_q && header_fec_q))
        else $error("CRC and FEC selected together");
    chk_half_lanes: assert property ((channel_active_q == 4'h3 &&
        $past(channel_active_q) == 4'h3 && $stable(nominal_lane_count))
        |-> lane_count_q == 4'(({1'b0, nominal_lane_count} + 5'h01) >> 1))
        else $error("lane count wrong with one pair off");
    chk_tick_pulse: assert property (link_tick_q |=> !link_tick_q)
        else $error("link tick longer than one cycle");
    chk_tick_rate: assert property (!link_tick_q |=> link_tick_q)
        else $error("link tick missed a link cycle");
    chk_level_low: assert property (!sync_n [*5] |-> !sync_level_q)
        else $error("sync level not low after sync low");
    chk_level_high: assert property (sync_n [*5] |-> sync_level_q)
        else $error("sync level not high after sync high");
    chk_req_drops: assert property (sync_level_q [*4] |-> !sync_request_q)
        else $error("request held while sync high");
    chk_err_single: assert property (sync_error_q |=> !sync_error_q)
        else $error("error pulse longer than one cycle");
    chk_err_not_req: assert property (!(sync_error_q && sync_request_q))
        else $error("error pulse during a request");
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Bench joining both ends, driving AHB-Lite and checking against a behavioural model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import slcs_pkg::*;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, seen_req, seen_err;
    logic [31:0] haddr, hwdata, hrdata, st, rd, seed, cmd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] nl, nc, act, lanes, convs, ea;
    logic tail, swap, crc, fec, tick, req, err, lvl, po;
    logic [7:0] v, d8;
    logic [7:0] chv [5] = '{8'h01, 8'h02, 8'h05, 8'hF9, 8'h03};
    int tv [3] = '{0, 2, 5};
    int err_total, n_compared, cycles, i, k, d;

    slcs_link_if slcs_link_if_inst ();
    slcs_host slcs_host_inst (.clk(clk), .rst(rst), .link(slcs_link_if_inst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    slcs_device slcs_device_inst (.clk(clk), .rst(rst), .link(slcs_link_if_inst),
        .nominal_lane_count(nl), .nominal_converter_count(nc), .channel_active_q(act),
        .lane_count_q(lanes), .converter_count_q(convs), .tail_pad_q(tail),
        .second_pair_in_first_slots_q(swap), .header_crc_q(crc), .header_fec_q(fec),
        .command_field_q(cmd), .link_tick_q(tick), .sync_request_q(req),
        .sync_error_q(err), .sync_level_q(lvl));
    slcs_link_assertions slcs_link_assertions_inst (.clk(clk), .rst(rst),
        .reg_req(slcs_link_if_inst.reg_req), .reg_ack(slcs_link_if_inst.reg_ack),
        .sync_n(slcs_link_if_inst.sync_n), .nominal_lane_count(nl), .channel_active_q(act),
        .lane_count_q(lanes), .header_crc_q(crc), .header_fec_q(fec), .command_field_q(cmd),
        .link_tick_q(tick), .sync_request_q(req), .sync_error_q(err), .sync_level_q(lvl));

    always #20 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (req === 1'b1) seen_req <= 1'b1;
        if (err === 1'b1) seen_err <= 1'b1;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Single AHB-Lite transfer; entered just after a rising edge.
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task wait_idle;
        do begin
            ahb(1'b0, AHB_OFS_STAT, 32'h0);
            st = rd;
        end while (st[STAT_BUSY] !== 1'b0);
    endtask

    task dev_wr(input logic [9:0] a, input logic [7:0] dat);
        ahb(1'b1, AHB_OFS_CMD, {1'b1, 13'h0, dat, a});
        wait_idle();
    endtask

    task dev_rd(input logic [9:0] a);
        ahb(1'b1, AHB_OFS_CMD, {1'b0, 13'h0, 8'h00, a});
        wait_idle();
        d8 = st[15:8];
    endtask

    task sync_low(input int n);
        ahb(1'b1, AHB_OFS_SYNC, 32'h0);
        repeat (n - 2) @(posedge clk);
        ahb(1'b1, AHB_OFS_SYNC, 32'h1);
    endtask

    initial begin
        clk = 0;
        rst = 1;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {err_total, n_compared, cycles} = '0;
        {seen_req, seen_err} = '0;
        seed = lfsr(32'hF13B);
        nl = 4'(seed[2:0]) + 4'h1;
        nc = 4'({seed[5:4], 1'b0}) + 4'h2;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        dev_rd(OFS_CHANNEL_PAIR_ENABLES);
        chk("chan reset", 8'h03, d8);
        dev_rd(OFS_HEADER_WORD_SELECT);
        chk("header reset", 8'h00, d8);
        dev_rd(OFS_SYNC_REQUEST_COUNT_LIMIT);
        chk("limit reset", 8'h03, d8);
        dev_rd(10'h3FF);
        chk("unmapped", 8'h00, d8);
        for (i = 0; i < 5; i++) begin
            dev_wr(OFS_CHANNEL_PAIR_ENABLES, chv[i]);
            v = chv[i] & 8'h07;
            ea = v[2] ? 4'h1 : {v[1], v[1], v[0], v[0]};
            po = v[2] || !v[0] || !v[1];
            repeat (2) @(posedge clk);
            chk("channels", ea, act);
            chk("lanes", po ? (nl + 1) / 2 : nl, lanes);
            chk("converters", po ? nc / 2 : nc, convs);
            chk("tail pad", po && nl[0], tail);
            chk("slot swap", !v[0] && v[1], swap);
            dev_rd(OFS_CHANNEL_PAIR_ENABLES);
            chk("chan readback", v, d8);
        end
        dev_wr(OFS_CHANNEL_PAIR_ENABLES, 8'h00);
        chk("all off refused", 1'b1, st[STAT_REFUSED]);
        chk("all off kept", 4'hF, act);
        ahb(1'b1, AHB_OFS_STAT, 32'h2);
        ahb(1'b0, AHB_OFS_STAT, 32'h0);
        chk("refused clear", 1'b0, rd[STAT_REFUSED]);
        dev_wr(OFS_LINK_CTRL, 8'h02);
        dev_wr(OFS_CHANNEL_PAIR_ENABLES, 8'h01);
        chk("cal on refused", 1'b1, st[STAT_REFUSED]);
        chk("cal on kept", 4'hF, act);
        ahb(1'b1, AHB_OFS_STAT, 32'h2);
        dev_wr(OFS_LINK_CTRL, 8'h04);
        for (i = 0; i < 4; i++) begin
            v = 8'((i + 1) % 4);
            dev_wr(OFS_HEADER_WORD_SELECT, v);
            repeat (2) @(posedge clk);
            chk("crc", v == 0, crc);
            chk("fec", v == 2, fec);
            dev_rd(OFS_HEADER_WORD_SELECT);
            chk("header readback", v, d8);
        end
        dev_wr(OFS_LINK_CTRL, 8'h01);
        repeat (2) @(posedge clk);
        chk("crc mode off", 1'b0, crc);
        dev_wr(OFS_HEADER_WORD_SELECT, 8'h02);
        chk("link on refused", 1'b1, st[STAT_REFUSED]);
        ahb(1'b1, AHB_OFS_STAT, 32'h2);
        dev_wr(OFS_LINK_CTRL, 8'h00);
        dev_rd(OFS_HEADER_WORD_SELECT);
        chk("header kept", 8'h00, d8);
        for (i = 0; i < 3; i++) begin
            dev_wr(OFS_SYNC_REQUEST_COUNT_LIMIT, 8'(tv[i]));
            for (k = 0; k < 2; k++) begin
                d = 2 * tv[i] + 2 * k;
                if (d > 0) begin
                    {seen_req, seen_err} = '0;
                    sync_low(d);
                    repeat (16) @(posedge clk);
                    chk("sync request", d / 2 >= tv[i] + 1, seen_req);
                    chk("sync error", d / 2 < tv[i] + 1, seen_err);
                end
            end
        end
        dev_wr(OFS_SYNC_REQUEST_COUNT_LIMIT, 8'h02);
        {seen_req, seen_err} = '0;
        sync_low(4);
        repeat (2) @(posedge clk);
        sync_low(4);
        repeat (16) @(posedge clk);
        chk("broken run", 1'b0, seen_req);
        ahb(1'b1, AHB_OFS_SYNC, 32'h0);
        // The input filter needs four edges before the sync level moves.
        repeat (4) @(posedge clk);
        dev_rd(OFS_LINK_STATUS);
        chk("status low", 1'b0, d8[BIT_SYNC_LEVEL]);
        chk("level low", 1'b0, lvl);
        ahb(1'b1, AHB_OFS_SYNC, 32'h1);
        repeat (4) @(posedge clk);
        dev_rd(OFS_LINK_STATUS);
        chk("status high", 1'b1, d8[BIT_SYNC_LEVEL]);
        chk("command zero", 32'h0, cmd);
        ahb(1'b0, AHB_OFS_SYNC, 32'h0);
        chk("sync readback", 32'h1, rd);
        chk("hresp okay", 32'h0, hresp);
        end_of_test();
    end
endmodule
`default_nettype wire
